//--- logic/bor_params.svh
`ifndef BOR_PARAMS_SVH
`define BOR_PARAMS_SVH

// Register map (byte address)
`define BOR_ADDR_BUS_OPTIONS 12'h020

// Field positions
`define BOR_CAP_HI 31
`define BOR_CAP_LO 27
`define BOR_RSV1_HI 26
`define BOR_RSV1_LO 24
`define BOR_CYC_HI 23
`define BOR_CYC_LO 16
`define BOR_MREC_HI 15
`define BOR_MREC_LO 12
`define BOR_RSV2_HI 11
`define BOR_RSV2_LO 8
`define BOR_GEN_HI 7
`define BOR_GEN_LO 6
`define BOR_RSV3_HI 5
`define BOR_RSV3_LO 3
`define BOR_SPD_HI 2
`define BOR_SPD_LO 0

// Reset and fixed values
`define BOR_CAP_RST 5'h00
`define BOR_CYC_RST 8'h00
`define BOR_MREC_RST 4'hB
`define BOR_MREC_MIN 4'h8
`define BOR_GEN_RST 2'h0
`define BOR_GEN_STEP 2'h1
`define BOR_LNK_SPD 3'h3
`define BOR_RSV1_VAL 3'h0
`define BOR_RSV2_VAL 4'h0
`define BOR_RSV3_VAL 3'h0
`define BOR_WORD_ZERO 32'h0000_0000
`define BOR_LIMIT_ONE 17'h0_0001
`define BOR_SHIFT_ONE 5'h01

`endif

//--- logic/bor_pkg.sv
package bor_pkg;
   typedef logic [3:0] bor_max_rec_type;
   typedef logic [15:0] bor_len_type;
   typedef logic [16:0] bor_limit_type;
   typedef logic [31:0] bor_word_type;
endpackage : bor_pkg

//--- logic/bor_len_check.sv
`timescale 1ns/10ps
`include "bor_params.svh"

module bor_len_check (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Received block write request
   input wire logic blk_wr_valid,
   input wire bor_pkg::bor_len_type blk_wr_len,
   input wire bor_pkg::bor_max_rec_type max_rec,
   // Verdict
   output logic type_err_ff
);
   bor_pkg::bor_limit_type limit;
   logic too_long;
   logic nxt_type_err;

   // Limit is 2^(max_rec+1) bytes; 17 bits hold the largest code
   assign limit = `BOR_LIMIT_ONE << (5'(max_rec) + `BOR_SHIFT_ONE);
   assign too_long = {1'b0, blk_wr_len} > limit;
   assign nxt_type_err = blk_wr_valid && too_long;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         type_err_ff <= 1'b0;
      end else begin
         type_err_ff <= nxt_type_err;
      end
   end

   AST_LEN_ERR: assert property (@(posedge clk) disable iff (!resetn)
      blk_wr_valid |=> type_err_ff == ({1'b0, $past(blk_wr_len)} >
         (`BOR_LIMIT_ONE << (5'($past(max_rec)) + `BOR_SHIFT_ONE))))
      else $error("Length error verdict wrong");
   AST_ERR_CAUSE: assert property (@(posedge clk) disable iff (!resetn)
      type_err_ff |-> $past(blk_wr_valid))
      else $error("Length error without request");

endmodule : bor_len_check

//--- logic/bor_bus_options.sv
`timescale 1ns/10ps
`include "bor_params.svh"

////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////

module bor_bus_options (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reset sources
   input wire logic function_reset_input_n,
   input wire logic soft_reset,
   // Link events
   input wire logic rom_changed,
   input wire logic bus_reset,
   input wire logic blk_wr_valid,
   input wire bor_pkg::bor_len_type blk_wr_len,
   // Results
   output logic ack_type_error,
   output logic [31:0] bus_info_quadlet
);

   ////////////////////////////////////////////////////////////////////////////
   // Function reset pin: three stages, change accepted when stages two and three agree
   logic fr_s1_ff, fr_s2_ff, fr_s3_ff, fr_lvl_ff;
   logic nxt_fr_lvl;
   logic fr_rst;

   assign nxt_fr_lvl = (fr_s2_ff == fr_s3_ff) ? fr_s3_ff : fr_lvl_ff;
   assign fr_rst = !fr_lvl_ff;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         fr_s1_ff <= 1'b1;
         fr_s2_ff <= 1'b1;
         fr_s3_ff <= 1'b1;
         fr_lvl_ff <= 1'b1;
      end else begin
         fr_s1_ff <= function_reset_input_n;
         fr_s2_ff <= fr_s1_ff;
         fr_s3_ff <= fr_s2_ff;
         fr_lvl_ff <= nxt_fr_lvl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB decode; one wait state keeps every bus output on a flip-flop
   logic hit;
   logic access;
   logic wr_hit;
   logic rd_done;
   logic nxt_pready;
   logic nxt_pslverr;
   logic [31:0] nxt_prdata;

   assign hit = paddr == `BOR_ADDR_BUS_OPTIONS;
   assign access = psel && penable && !pready;
   assign wr_hit = psel && penable && pready && pwrite && hit;
   assign rd_done = psel && penable && pready;
   assign nxt_pready = access;
   assign nxt_pslverr = access && !hit;

   ////////////////////////////////////////////////////////////////////////////
   // Fields
   logic [4:0] cap_ff, nxt_cap;
   logic [7:0] cyc_ff, nxt_cyc;
   bor_pkg::bor_max_rec_type mrec_ff, nxt_mrec;
   logic [1:0] gen_ff, nxt_gen;
   logic dirty_ff, nxt_dirty;
   logic field_rst;
   logic mrec_rst;
   logic mrec_wr_ok;
   logic gen_bump;
   logic [31:0] word;

   // Soft reset clears ordinary fields but never the exponent
   assign field_rst = fr_rst || soft_reset;
   assign mrec_rst = fr_rst;
   // Codes below 8 would give less than 512 bytes; such writes keep the old code
   assign mrec_wr_ok = pwdata[`BOR_MREC_HI:`BOR_MREC_LO] >= `BOR_MREC_MIN;
   assign gen_bump = bus_reset && dirty_ff;

   assign nxt_cap = field_rst ? `BOR_CAP_RST :
      wr_hit ? pwdata[`BOR_CAP_HI:`BOR_CAP_LO] : cap_ff;
   assign nxt_cyc = field_rst ? `BOR_CYC_RST :
      wr_hit ? pwdata[`BOR_CYC_HI:`BOR_CYC_LO] : cyc_ff;
   assign nxt_mrec = mrec_rst ? `BOR_MREC_RST :
      (wr_hit && mrec_wr_ok) ? pwdata[`BOR_MREC_HI:`BOR_MREC_LO] : mrec_ff;
   // Bus reset increment wins over a software write in the same cycle
   assign nxt_gen = field_rst ? `BOR_GEN_RST :
      gen_bump ? gen_ff + `BOR_GEN_STEP :
      wr_hit ? pwdata[`BOR_GEN_HI:`BOR_GEN_LO] : gen_ff;
   // A change arriving with the bus reset is kept for the next one
   assign nxt_dirty = field_rst ? 1'b0 : (rom_changed || (dirty_ff && !bus_reset));

   // Fixed bits are built in, so write data never reaches them
   assign word = {cap_ff, `BOR_RSV1_VAL, cyc_ff, mrec_ff, `BOR_RSV2_VAL,
      gen_ff, `BOR_RSV3_VAL, `BOR_LNK_SPD};
   assign nxt_prdata = (access && hit && !pwrite) ? word : `BOR_WORD_ZERO;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cap_ff <= `BOR_CAP_RST;
         cyc_ff <= `BOR_CYC_RST;
         gen_ff <= `BOR_GEN_RST;
         dirty_ff <= 1'b0;
      end else begin
         cap_ff <= nxt_cap;
         cyc_ff <= nxt_cyc;
         gen_ff <= nxt_gen;
         dirty_ff <= nxt_dirty;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         mrec_ff <= `BOR_MREC_RST;
      end else begin
         mrec_ff <= nxt_mrec;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `BOR_WORD_ZERO;
         bus_info_quadlet <= `BOR_WORD_ZERO;
      end else begin
         pready <= nxt_pready;
         pslverr <= nxt_pslverr;
         prdata <= nxt_prdata;
         bus_info_quadlet <= word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Length check against the live exponent
   bor_len_check u_len_check (
      .clk(clk),
      .resetn(resetn),
      .blk_wr_valid(blk_wr_valid),
      .blk_wr_len(blk_wr_len),
      .max_rec(mrec_ff),
      .type_err_ff(ack_type_error)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_CAP_RESET: assert property (@(posedge clk)
      !resetn |=> cap_ff == `BOR_CAP_RST && cyc_ff == `BOR_CYC_RST)
      else $error("Flags or accuracy not cleared by reset");
   AST_CAP_WRITE: assert property (@(posedge clk) disable iff (!resetn)
      wr_hit && !field_rst |=> cap_ff == $past(pwdata[`BOR_CAP_HI:`BOR_CAP_LO]))
      else $error("Capability write lost");
   AST_CYC_WRITE: assert property (@(posedge clk) disable iff (!resetn)
      wr_hit && !field_rst |=> cyc_ff == $past(pwdata[`BOR_CYC_HI:`BOR_CYC_LO]))
      else $error("Accuracy write lost");
   AST_MREC_MIN: assert property (@(posedge clk) disable iff (!resetn)
      mrec_ff >= `BOR_MREC_MIN)
      else $error("Exponent below 512 bytes");
   AST_MREC_HW: assert property (@(posedge clk)
      !resetn |=> mrec_ff == `BOR_MREC_RST)
      else $error("Exponent not Bh after reset");
   AST_MREC_SOFT: assert property (@(posedge clk) disable iff (!resetn)
      soft_reset && !fr_rst && !wr_hit |=> $stable(mrec_ff))
      else $error("Soft reset touched exponent");
   // The filtered level falls one edge before the exponent is reloaded
   AST_MREC_PIN: assert property (@(posedge clk) disable iff (!resetn)
      $fell(fr_lvl_ff) |=> mrec_ff == `BOR_MREC_RST ##1 mrec_ff == `BOR_MREC_RST)
      else $error("Function reset missed exponent");
   AST_GEN_BUMP: assert property (@(posedge clk) disable iff (!resetn)
      gen_bump && !field_rst |=> gen_ff == $past(gen_ff) + `BOR_GEN_STEP)
      else $error("Generation not incremented");
   AST_GEN_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      bus_reset && !dirty_ff && !wr_hit && !field_rst |=> $stable(gen_ff))
      else $error("Generation moved without change");
   AST_FIXED: assert property (@(posedge clk) disable iff (!resetn)
      rd_done && hit && !pwrite |-> prdata[`BOR_SPD_HI:`BOR_SPD_LO] == `BOR_LNK_SPD
      && prdata[`BOR_RSV1_HI:`BOR_RSV1_LO] == `BOR_RSV1_VAL
      && prdata[`BOR_RSV2_HI:`BOR_RSV2_LO] == `BOR_RSV2_VAL
      && prdata[`BOR_RSV3_HI:`BOR_RSV3_LO] == `BOR_RSV3_VAL)
      else $error("Fixed bits read wrong");
   // Image two edges on shows the written flags but never written fixed bits
   AST_RO_WRITE: assert property (@(posedge clk) disable iff (!resetn)
      wr_hit && !field_rst |=> ##1
      bus_info_quadlet[`BOR_SPD_HI:`BOR_SPD_LO] == `BOR_LNK_SPD
      && bus_info_quadlet[`BOR_RSV2_HI:`BOR_RSV2_LO] == `BOR_RSV2_VAL
      && bus_info_quadlet[`BOR_CAP_HI:`BOR_CAP_LO] ==
      $past(pwdata[`BOR_CAP_HI:`BOR_CAP_LO], 2))
      else $error("Write reached fixed bits or image lost it");
   AST_MAP: assert property (@(posedge clk) disable iff (!resetn)
      psel && !penable ##1 psel && penable |-> ##1 pready && (pslverr == !hit))
      else $error("Bus answer wrong");

   COV_WRITE: cover property (@(posedge clk) disable iff (!resetn) wr_hit);
   COV_READ: cover property (@(posedge clk) disable iff (!resetn) rd_done && hit && !pwrite);
   COV_BUMP: cover property (@(posedge clk) disable iff (!resetn) gen_bump);
   COV_TYPE_ERR: cover property (@(posedge clk) disable iff (!resetn) ack_type_error);
   COV_FN_RESET: cover property (@(posedge clk) disable iff (!resetn) $fell(fr_lvl_ff));

endmodule : bor_bus_options

//--- sim/bor_bus_options_tb.sv
`timescale 1ns/10ps
`include "bor_params.svh"

module bus_options_register_tb_top;
   logic clk;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic function_reset_input_n = 1'b1;
   logic soft_reset = 1'b0;
   logic rom_changed = 1'b0;
   logic bus_reset = 1'b0;
   logic blk_wr_valid = 1'b0;
   bor_pkg::bor_len_type blk_wr_len = 16'h0000;
   logic ack_type_error;
   logic [31:0] bus_info_quadlet;
   int failures = 0;
   int checks_done = 0;
   bor_pkg::bor_word_type expw = 32'h0000_B003;
   bor_pkg::bor_word_type rd;
   logic err;

   bor_bus_options dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .function_reset_input_n(function_reset_input_n),
      .soft_reset(soft_reset), .rom_changed(rom_changed), .bus_reset(bus_reset),
      .blk_wr_valid(blk_wr_valid), .blk_wr_len(blk_wr_len),
      .ack_type_error(ack_type_error), .bus_info_quadlet(bus_info_quadlet));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Expectations, comparison and bus tasks
   // Exponent writes below 8 would fall under 512 bytes, so the field keeps its value
   function automatic bor_pkg::bor_word_type after_write(bor_pkg::bor_word_type o,
                                                        bor_pkg::bor_word_type w);
      after_write = {w[31:27], 3'h0, w[23:16], (w[15:12] >= 4'h8) ? w[15:12] : o[15:12],
                     4'h0, w[7:6], 3'h0, 3'h3};
   endfunction : after_write

   task automatic check(input string name, input bor_pkg::bor_word_type seen,
                        input bor_pkg::bor_word_type exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("Checks done %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic apb(input logic wr, input logic [11:0] a, input bor_pkg::bor_word_type d,
                      output bor_pkg::bor_word_type q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Request stands until pready is seen high at a rising edge; only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr_reg(input bor_pkg::bor_word_type d);
      apb(1'b1, `BOR_ADDR_BUS_OPTIONS, d, rd, err);
      expw = after_write(expw, d);
      check("write pslverr", {31'h0, err}, 32'h0);
   endtask : wr_reg

   task automatic rd_chk(input string name);
      apb(1'b0, `BOR_ADDR_BUS_OPTIONS, 32'h0000_0000, rd, err);
      check(name, rd, expw);
      check("bus_info_quadlet", bus_info_quadlet, expw);
   endtask : rd_chk

   task automatic pulse_ev(input logic is_bus);
      @(posedge clk);
      if (is_bus) bus_reset <= 1'b1;
      else rom_changed <= 1'b1;
      @(posedge clk);
      bus_reset <= 1'b0;
      rom_changed <= 1'b0;
   endtask : pulse_ev

   task automatic blk(input bor_pkg::bor_len_type l);
      logic [16:0] lim;
      logic ex;
      lim = 17'h0_0001 << (expw[15:12] + 5'h01);
      ex = {1'b0, l} > lim;
      @(posedge clk);
      blk_wr_valid <= 1'b1;
      blk_wr_len <= l;
      @(posedge clk);
      blk_wr_valid <= 1'b0;
      @(negedge clk);
      check("ack_type_error", {31'h0, ack_type_error}, {31'h0, ex});
      @(negedge clk);
      check("ack_type_error idle", {31'h0, ack_type_error}, 32'h0);
   endtask : blk

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      tally_and_finish();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      bor_pkg::bor_word_type corners [4];
      logic [16:0] lim;
      corners = '{32'hFFFF_FFFF, 32'h0000_7000, 32'h0000_8000, 32'h5A5A_A5A5};
      void'($urandom(32'hB943CB91));
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      rd_chk("reset value");
      // Fields loaded before any link activation, as software must
      foreach (corners[i]) begin
         wr_reg(corners[i]);
         rd_chk("corner write");
      end
      repeat (24) begin
         wr_reg($urandom());
         if ($urandom_range(1) == 1) rd_chk("random write");
      end
      rd_chk("after random writes");
      apb(1'b1, 12'h024, 32'hFFFF_FFFF, rd, err);
      check("unmapped write err", {31'h0, err}, 32'h1);
      apb(1'b0, 12'h024, 32'h0000_0000, rd, err);
      check("unmapped read", rd, 32'h0);
      rd_chk("after unmapped");
      // Five rounds so the count wraps through zero
      repeat (5) begin
         pulse_ev(1'b0);
         pulse_ev(1'b1);
         repeat (2) @(posedge clk);
         expw[7:6] = expw[7:6] + 2'h1;
         rd_chk("generation");
      end
      pulse_ev(1'b1);
      rd_chk("bus reset without change");
      for (int m = 8; m < 16; m++) begin
         wr_reg({expw[31:16], m[3:0], expw[11:0]});
         lim = 17'h0_0001 << (m + 1);
         blk(lim[15:0]);
         blk(lim[15:0] + 16'h0001);
         blk(16'($urandom()));
      end
      wr_reg(32'hF8FF_9040);
      @(posedge clk);
      soft_reset <= 1'b1;
      @(posedge clk);
      soft_reset <= 1'b0;
      expw = {16'h0000, expw[15:12], 12'h003};
      rd_chk("soft reset keeps exponent");
      wr_reg(32'hFFFF_FFFF);
      @(posedge clk);
      function_reset_input_n <= 1'b0;
      repeat (8) @(posedge clk);
      function_reset_input_n <= 1'b1;
      repeat (8) @(posedge clk);
      expw = 32'h0000_B003;
      rd_chk("function reset");
      wr_reg(32'h0000_9000);
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      expw = 32'h0000_B003;
      rd_chk("hardware reset mid run");
      tally_and_finish();
   end
endmodule : bus_options_register_tb_top
